/* File: common/radio_regs_pkg.sv */
// constants for the identity, sequencer timing and override register bank
// assumes one 100 MHz clock and a synchronous active-low reset
package radio_regs_pkg;
  // register offsets on the configuration port
  localparam logic [5:0] ADDR_ID_LOW = 6'h1E;
  localparam logic [5:0] ADDR_ID_HIGH = 6'h1F;
  localparam logic [5:0] ADDR_TIME_CONST = 6'h20;
  localparam logic [5:0] ADDR_AND_MASK = 6'h21;
  localparam logic [5:0] ADDR_OR_MASK = 6'h22;
  localparam int CTRL_W = 16;
  // identity values, all arbitrary
  localparam logic [15:0] PART_NUMBER = 16'h0A51;
  localparam logic [3:0] REVISION = 4'h1;
  localparam logic [6:0] MAKER_CODE = 7'h35;
  localparam logic [3:0] MAKER_CONT = 4'h1;
  localparam logic [15:0] ID_LOW_VALUE = {PART_NUMBER[3:0], MAKER_CONT, MAKER_CODE, 1'b1};
  localparam logic [15:0] ID_HIGH_VALUE = {REVISION, PART_NUMBER[15:4]};
  // time constant field positions and reset values
  localparam int RXW_LSB = 13;
  localparam int SWL_LSB = 10;
  localparam int AMPL_LSB = 6;
  localparam int TSW_LSB = 3;
  localparam int TPA_LSB = 0;
  localparam logic [2:0] RXW_RESET = 3'h3;
  localparam logic [2:0] SWL_RESET = 3'h6;
  localparam logic [3:0] AMPL_RESET = 4'hA;
  localparam logic [2:0] TSW_RESET = 3'h2;
  localparam logic [2:0] TPA_RESET = 3'h4;
  localparam logic [15:0] TC_RESET = {RXW_RESET, SWL_RESET, AMPL_RESET, TSW_RESET, TPA_RESET};
  localparam logic [15:0] AND_RESET = 16'hFFFF;
  localparam logic [15:0] OR_RESET = 16'h0000;
  // override bit positions
  localparam int BIT_PEAK_RST_N = 15;
  localparam int BIT_GLOBAL_BIAS_POWERDOWN = 14;
  localparam int BIT_AMP_BIAS_SW = 13;
  localparam int BIT_BUF_SEL = 12;
  localparam int BIT_PRESCALER_PD = 11;
  localparam int BIT_AMP_NEG_PD = 10;
  localparam int BIT_AMP_POS_PD = 9;
  localparam int BIT_TX_CONV_PD = 8;
  localparam int BIT_CRYSTAL_PD = 7;
  localparam int BIT_CAL_OSC_PD = 6;
  localparam int BIT_CHARGE_PUMP_PD = 5;
  localparam int BIT_SYNTH_PD = 4;
  localparam int BIT_CONVERTER_PD = 3;
  localparam int BIT_VGAIN_PD = 2;
  localparam int BIT_RX_FILTER_PD = 1;
  localparam int BIT_FRONTEND_PD = 0;
  // timebase
  localparam int US_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CYCLES_PER_US = US_NS / CLK_PERIOD_NS;
  localparam int RX_STEP_US = 5;
  localparam logic [6:0] US_DIV_MAX = 7'(CYCLES_PER_US - 1);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX_WAIT = 6'h02,
    ST_RX_ON = 6'h04,
    ST_TX_LEAD = 6'h08,
    ST_TX_ON = 6'h10,
    ST_TX_TAIL = 6'h20
  } seq_state_e;
endpackage

/* File: common/override_if.sv */
// carrier between the bank and its override stage
// assumes both ends run on the same clock
interface override_if;
  import radio_regs_pkg::*;
  logic [CTRL_W-1:0] internal;
  logic [CTRL_W-1:0] and_mask;
  logic [CTRL_W-1:0] or_mask;
  logic [CTRL_W-1:0] used;
  logic pair_pd;
  modport stage (input internal, input and_mask, input or_mask, output used, output pair_pd);
  modport owner (output internal, output and_mask, output or_mask, input used, input pair_pd);
endinterface

/* File: core/override_stage.sv */
// and/or override of the internal control vector, registered
// assumes masks and internal values are synchronous to i_clk
module override_stage
  import radio_regs_pkg::*;
#(
  parameter int PAIR_A = 10,
  parameter int PAIR_B = 9
)(
  input wire logic i_clk,
  input wire logic i_rst_n,
  override_if.stage ovr
);
  typedef struct packed {
    logic [CTRL_W-1:0] used;
    logic pair_pd;
  } stage_s;
  stage_s state_reg;
  stage_s state_next;
  logic [CTRL_W-1:0] used_v;

  // used = internal and mask, or mask, every cycle
  always_comb
  begin
    used_v = (ovr.internal & ovr.and_mask) | ovr.or_mask;
    state_next.used = used_v;
    state_next.pair_pd = used_v[PAIR_A] & used_v[PAIR_B];
  end

  // register the combined vector
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign ovr.used = state_reg.used;
  assign ovr.pair_pd = state_reg.pair_pd;
endmodule // override_stage

/* File: core/radio_id_timing_override_regs.sv */
// identity, sequencer time constant and override mask registers with tx/rx sequencing
// assumes register strobes from the serial port decoder, synchronous to i_clk
// Overview of operation
// - the lower identity register is read-only: low part-number nibble over the maker field.
// - the maker field holds the maker code in 7:1, continuation count in 11:8, a one in bit 0.
// - the upper identity register reads the revision over the upper twelve part-number bits.
// - after the rx chain starts, demodulator enable waits the programmed count of 5 us steps.
// - the tx/rx switch rises the programmed microseconds before tx is enabled.
// - the amplifier powers up the programmed microseconds before tx is enabled.
// - after the last chip the switch falls once its programmed delay has passed.
// - after the last chip the amplifier powers down and the modulator stops after their delay.
// - each used control bit is the internal bit and the and-mask, or the or-mask.
// - mask bits 15..8: peak reset, bias, amp switch, buffer, prescaler, amp n/p, tx dac.
// - mask bits 7..0: crystal, cal osc, charge pump, synth, adc, vga, rx filter, frontend.
// - with both amplifier path power-downs used high, the up-conversion mixers power down too.
module radio_id_timing_override_regs
  import radio_regs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_rx_chain_on,
  input wire logic i_rx_stop,
  input wire logic i_tx_start,
  input wire logic i_tx_last_chip,
  input wire logic [15:0] i_ctrl_internal,
  output logic [15:0] o_reg_rdata,
  output logic o_demod_enable,
  output logic o_tx_enable,
  output logic o_mod_enable,
  output logic o_switch_ctrl,
  output logic o_amp_powered,
  output logic [15:0] o_used_ctrl,
  output logic o_upmix_powerdown
);
  typedef struct packed {
    seq_state_e state;
    logic [6:0] div;
    logic [5:0] us;
    logic [5:0] lead;
    logic [15:0] tc;
    logic [15:0] and_m;
    logic [15:0] or_m;
    logic [15:0] rdata;
    logic demod;
    logic tx;
    logic mod;
    logic sw;
    logic amp;
  } bank_s;

  localparam bank_s BANK_RESET = '{state: ST_IDLE, div: '0, us: '0, lead: '0, tc: TC_RESET,
    and_m: AND_RESET, or_m: OR_RESET, rdata: '0, demod: 1'b0, tx: 1'b0, mod: 1'b0,
    sw: 1'b0, amp: 1'b0};

  bank_s state_reg;
  bank_s state_next;
  logic [2:0] rx_steps;
  logic [5:0] rx_target;
  logic [5:0] sw_lead;
  logic [5:0] amp_lead;
  logic [5:0] end_sw;
  logic [5:0] end_amp;

  override_if ovr();

  // time constant fields widened to the microsecond counter
  assign rx_steps = state_reg.tc[RXW_LSB +: 3];
  assign rx_target = {3'h0, rx_steps} * 6'(RX_STEP_US);
  assign sw_lead = {3'h0, state_reg.tc[SWL_LSB +: 3]};
  assign amp_lead = {2'h0, state_reg.tc[AMPL_LSB +: 4]};
  assign end_sw = {3'h0, state_reg.tc[TSW_LSB +: 3]};
  assign end_amp = {3'h0, state_reg.tc[TPA_LSB +: 3]};

  // registers, timebase and sequencer
  always_comb
  begin
    state_next = state_reg;
    // microsecond timebase, counter saturates
    if (state_reg.div == US_DIV_MAX)
    begin
      state_next.div = '0;
      if (state_reg.us != 6'h3F)
        state_next.us = state_reg.us + 6'h01;
    end
    else
      state_next.div = state_reg.div + 7'h01;
    // writes; identity offsets fall to default and are ignored
    if (i_reg_wr)
    begin
      case (i_reg_addr)
        ADDR_TIME_CONST: state_next.tc = i_reg_wdata;
        ADDR_AND_MASK: state_next.and_m = i_reg_wdata;
        ADDR_OR_MASK: state_next.or_m = i_reg_wdata;
        default: ;
      endcase
    end
    // reads; unmapped offsets read zero
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        ADDR_ID_LOW: state_next.rdata = ID_LOW_VALUE;
        ADDR_ID_HIGH: state_next.rdata = ID_HIGH_VALUE;
        ADDR_TIME_CONST: state_next.rdata = state_reg.tc;
        ADDR_AND_MASK: state_next.rdata = state_reg.and_m;
        ADDR_OR_MASK: state_next.rdata = state_reg.or_m;
        default: state_next.rdata = '0;
      endcase
    end
    // sequencer
    case (state_reg.state)
      ST_IDLE, ST_RX_WAIT, ST_RX_ON:
      begin
        if (i_tx_start)
        begin
          state_next.state = ST_TX_LEAD;
          state_next.div = '0;
          state_next.us = '0;
          state_next.demod = 1'b0;
          state_next.lead = (amp_lead >= sw_lead) ? amp_lead : sw_lead;
        end
        else if (state_reg.state == ST_IDLE)
        begin
          if (i_rx_chain_on)
          begin
            state_next.state = ST_RX_WAIT;
            state_next.div = '0;
            state_next.us = '0;
          end
        end
        else if (state_reg.state == ST_RX_WAIT)
        begin
          if (state_reg.us >= rx_target)
          begin
            state_next.demod = 1'b1;
            state_next.state = ST_RX_ON;
          end
        end
        else if (i_rx_stop)
        begin
          state_next.demod = 1'b0;
          state_next.state = ST_IDLE;
        end
      end
      ST_TX_LEAD:
      begin
        if (state_reg.us >= state_reg.lead - amp_lead)
          state_next.amp = 1'b1;
        if (state_reg.us >= state_reg.lead - sw_lead)
          state_next.sw = 1'b1;
        if (state_reg.us >= state_reg.lead)
        begin
          state_next.tx = 1'b1;
          state_next.mod = 1'b1;
          state_next.state = ST_TX_ON;
        end
      end
      ST_TX_ON:
      begin
        if (i_tx_last_chip)
        begin
          state_next.tx = 1'b0;
          state_next.div = '0;
          state_next.us = '0;
          state_next.state = ST_TX_TAIL;
        end
      end
      ST_TX_TAIL:
      begin
        if (state_reg.us >= end_sw)
          state_next.sw = 1'b0;
        if (state_reg.us >= end_amp)
        begin
          state_next.amp = 1'b0;
          state_next.mod = 1'b0;
        end
        if (!state_next.sw && !state_next.amp)
          state_next.state = ST_IDLE;
      end
      default: state_next = BANK_RESET;
    endcase
  end

  // state register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      state_reg <= BANK_RESET;
    else
      state_reg <= state_next;
  end

  // internal control vector, sequencer owns the amplifier bits
  always_comb
  begin
    ovr.internal = i_ctrl_internal;
    ovr.internal[BIT_AMP_BIAS_SW] = state_reg.sw;
    ovr.internal[BIT_BUF_SEL] = state_reg.amp;
    ovr.internal[BIT_AMP_NEG_PD] = ~state_reg.amp;
    ovr.internal[BIT_AMP_POS_PD] = ~state_reg.amp;
  end
  assign ovr.and_mask = state_reg.and_m;
  assign ovr.or_mask = state_reg.or_m;

  override_stage #(
    .PAIR_A(BIT_AMP_NEG_PD),
    .PAIR_B(BIT_AMP_POS_PD)
  ) u_override (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .ovr(ovr)
  );

  // outputs straight from flops
  assign o_reg_rdata = state_reg.rdata;
  assign o_demod_enable = state_reg.demod;
  assign o_tx_enable = state_reg.tx;
  assign o_mod_enable = state_reg.mod;
  assign o_switch_ctrl = state_reg.sw;
  assign o_amp_powered = state_reg.amp;
  assign o_used_ctrl = ovr.used;
  assign o_upmix_powerdown = ovr.pair_pd;

  // helper counters for timing checks
  logic [10:0] sw_cyc;
  logic [10:0] amp_cyc;
  logic [10:0] tail_cyc;
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sw_cyc <= '0;
      amp_cyc <= '0;
      tail_cyc <= '0;
    end
    else
    begin
      sw_cyc <= state_reg.sw ? sw_cyc + 11'h001 : 11'h000;
      amp_cyc <= state_reg.amp ? amp_cyc + 11'h001 : 11'h000;
      tail_cyc <= (state_reg.tx || tail_cyc == 11'h7FF) ? 11'h000 : tail_cyc + 11'h001;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  chk_id_low_read: assert property (i_reg_rd && i_reg_addr == ADDR_ID_LOW |=>
    o_reg_rdata == ID_LOW_VALUE) else $error("identity low read wrong");
  chk_maker_field_bits: assert property (i_reg_rd && i_reg_addr == ADDR_ID_LOW |=>
    o_reg_rdata[0] && o_reg_rdata[11:8] == MAKER_CONT && o_reg_rdata[7:1] == MAKER_CODE)
    else $error("maker field layout wrong");
  chk_id_write_ignored: assert property (i_reg_wr && (i_reg_addr == ADDR_ID_LOW ||
    i_reg_addr == ADDR_ID_HIGH) |=> $stable(state_reg.tc) && $stable(state_reg.and_m) &&
    $stable(state_reg.or_m)) else $error("identity write changed a register");
  chk_id_high_read: assert property (i_reg_rd && i_reg_addr == ADDR_ID_HIGH |=>
    o_reg_rdata[15:12] == REVISION && o_reg_rdata[11:0] == PART_NUMBER[15:4])
    else $error("identity high read wrong");
  chk_rx_demod_wait: assert property ($rose(o_demod_enable) |->
    $past(state_reg.us) == $past(rx_target)) else $error("demod enabled at wrong time");
  chk_switch_lead_time: assert property ($rose(o_tx_enable) |->
    sw_cyc == 11'(sw_lead * CYCLES_PER_US)) else $error("switch lead wrong");
  chk_amp_lead_time: assert property ($rose(o_tx_enable) |->
    amp_cyc == 11'(amp_lead * CYCLES_PER_US)) else $error("amplifier lead wrong");
  chk_switch_tail_time: assert property ($fell(o_switch_ctrl) |->
    tail_cyc == 11'(end_sw * CYCLES_PER_US + 1)) else $error("switch tail wrong");
  chk_amp_tail_time: assert property ($fell(o_amp_powered) |->
    tail_cyc == 11'(end_amp * CYCLES_PER_US + 1) && !o_mod_enable)
    else $error("amplifier tail wrong");
  chk_override_combine: assert property (i_rst_n |=> o_used_ctrl ==
    $past((ovr.internal & ovr.and_mask) | ovr.or_mask)) else $error("override value wrong");
  chk_amp_bits_order: assert property (i_rst_n && !o_amp_powered &&
    state_reg.and_m == AND_RESET && state_reg.or_m == OR_RESET ##1 $stable(state_reg.and_m)
    |-> o_used_ctrl[BIT_AMP_NEG_PD] && o_used_ctrl[BIT_AMP_POS_PD])
    else $error("amplifier power-down bits misplaced");
  chk_frontend_force: assert property (i_reg_wr && i_reg_addr == ADDR_OR_MASK &&
    i_reg_wdata == 16'h0001 ##1 !i_reg_wr |=> o_used_ctrl[BIT_FRONTEND_PD])
    else $error("frontend override bit misplaced");
  chk_upmix_pair: assert property (o_upmix_powerdown ==
    (o_used_ctrl[BIT_AMP_NEG_PD] && o_used_ctrl[BIT_AMP_POS_PD])) else $error("mixer pd wrong");

  cov_rx_demod: cover property ($rose(o_demod_enable));
  cov_tx_full: cover property ($rose(o_tx_enable) ##[1:1000] $fell(o_amp_powered));
  cov_mask_force: cover property (i_reg_wr && i_reg_addr == ADDR_AND_MASK);
endmodule // radio_id_timing_override_regs

/* File: tb/host_model.sv */
// host side model that reaches the bank through its register strobes
// assumes the bank samples strobes on the rising edge of i_clk
module host_model
  import radio_regs_pkg::*;
(
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  output logic [5:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle lines before the first access
  initial
  begin
    o_addr = 6'h3F;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end

  // one write strobe; released lines are inverted so no stale value lingers
  task automatic write(input logic [5:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask

  // one read strobe; data taken once the registered answer has landed
  task automatic read(input logic [5:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk);
    #1;
    d = i_rdata;
  endtask
endmodule // host_model

/* File: tb/testbench.sv */
// self-checking bench for the identity, timing and override register bank
// assumes a 100 MHz clock and the host model driving the register strobes
module testbench;
  import radio_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int AMP = 0;
  localparam int SW = 1;
  localparam int MOD = 2;
  localparam int TX = 3;
  localparam int DEM = 4;
  logic i_clk = 1'b0;
  logic i_rst_n;
  logic [5:0] i_reg_addr;
  logic i_reg_wr;
  logic i_reg_rd;
  logic [15:0] i_reg_wdata;
  logic i_rx_chain_on;
  logic i_rx_stop;
  logic i_tx_start;
  logic i_tx_last_chip;
  logic [15:0] i_ctrl_internal;
  logic [15:0] o_reg_rdata;
  logic o_demod_enable;
  logic o_tx_enable;
  logic o_mod_enable;
  logic o_switch_ctrl;
  logic o_amp_powered;
  logic [15:0] o_used_ctrl;
  logic o_upmix_powerdown;
  logic [4:0] seq;
  logic [4:0] pa;
  logic [15:0] d;
  logic [15:0] iv;
  logic [15:0] e;
  int mismatches = 0;
  int n_checks = 0;
  int t_edge[5];
  // internal, and-mask, or-mask per override case
  logic [15:0] ov[5][3] = '{'{16'h5A3C, 16'hFFFF, 16'h0000}, '{16'h5A3C, 16'hFFFE, 16'h0000},
    '{16'hA5C3, 16'hFFFF, 16'h0001}, '{16'h1234, 16'hFBFF, 16'h0000},
    '{16'hFFFF, 16'h0000, 16'h8421}};

  // clock and sequencer output vector
  always #5 i_clk = ~i_clk;
  assign seq = {o_demod_enable, o_tx_enable, o_mod_enable, o_switch_ctrl, o_amp_powered};
  assign pa = {o_used_ctrl[13:12], o_used_ctrl[10:9], o_upmix_powerdown};

  radio_id_timing_override_regs radio_id_timing_override_regs_i (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .i_rx_chain_on(i_rx_chain_on), .i_rx_stop(i_rx_stop),
    .i_tx_start(i_tx_start), .i_tx_last_chip(i_tx_last_chip), .i_ctrl_internal(i_ctrl_internal),
    .o_reg_rdata(o_reg_rdata), .o_demod_enable(o_demod_enable), .o_tx_enable(o_tx_enable),
    .o_mod_enable(o_mod_enable), .o_switch_ctrl(o_switch_ctrl), .o_amp_powered(o_amp_powered),
    .o_used_ctrl(o_used_ctrl), .o_upmix_powerdown(o_upmix_powerdown));

  host_model host_model_i (.i_clk(i_clk), .i_rdata(o_reg_rdata), .o_addr(i_reg_addr),
    .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_wdata(i_reg_wdata));

  // compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one-cycle sequencer pulse, returns just after its sampling edge
  task automatic pulse(input int which);
    @(posedge i_clk);
    case (which)
      0: i_tx_start <= 1'b1;
      1: i_tx_last_chip <= 1'b1;
      2: i_rx_chain_on <= 1'b1;
      default: i_rx_stop <= 1'b1;
    endcase
    @(posedge i_clk);
    i_tx_start <= 1'b0;
    i_tx_last_chip <= 1'b0;
    i_rx_chain_on <= 1'b0;
    i_rx_stop <= 1'b0;
    #1;
  endtask

  // cycle of first change of each sequencer output, -1 if none
  task automatic watch(input int lim);
    logic [4:0] s0;
    s0 = seq;
    for (int b = 0; b < 5; b++)
      t_edge[b] = -1;
    for (int n = 0; n < lim; n++)
    begin
      @(posedge i_clk);
      #1;
      for (int b = 0; b < 5; b++)
        if (t_edge[b] < 0 && seq[b] !== s0[b])
          t_edge[b] = n + 1;
    end
  endtask

  // counts, verdict and end of run
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial
  begin
    i_rst_n = 1'b0;
    i_rx_chain_on = 1'b0;
    i_rx_stop = 1'b0;
    i_tx_start = 1'b0;
    i_tx_last_chip = 1'b0;
    i_ctrl_internal = 16'h0000;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    // identity and reset values, writes to read-only and unmapped places
    host_model_i.write(ADDR_ID_LOW, 16'h0000);
    host_model_i.write(ADDR_ID_HIGH, 16'h0000);
    host_model_i.write(6'h23, 16'h5555);
    host_model_i.read(ADDR_ID_LOW, d);
    check(d, {PART_NUMBER[3:0], MAKER_CONT, MAKER_CODE, 1'b1}, "id low");
    host_model_i.read(ADDR_ID_HIGH, d);
    check(d, {REVISION, PART_NUMBER[15:4]}, "id high");
    host_model_i.read(ADDR_TIME_CONST, d);
    check(d, {3'h3, 3'h6, 4'hA, 3'h2, 3'h4}, "tc rst");
    host_model_i.read(ADDR_AND_MASK, d);
    check(d, 16'hFFFF, "and reset");
    host_model_i.read(ADDR_OR_MASK, d);
    check(d, 16'h0000, "or reset");
    host_model_i.read(6'h23, d);
    check(d, 16'h0000, "unmapped");
    // override combination over a table of cases
    for (int k = 0; k < 5; k++)
    begin
      @(posedge i_clk);
      i_ctrl_internal <= ov[k][0];
      host_model_i.write(ADDR_AND_MASK, ov[k][1]);
      host_model_i.write(ADDR_OR_MASK, ov[k][2]);
      repeat (2) @(posedge i_clk);
      #1;
      iv = (ov[k][0] & 16'hC9FF) | 16'h0600;
      e = (iv & ov[k][1]) | ov[k][2];
      check(o_used_ctrl, e, "used ctrl");
      check({15'h0000, o_upmix_powerdown}, {15'h0000, e[10] & e[9]}, "upmix");
    end
    host_model_i.write(ADDR_AND_MASK, 16'hFFFF);
    host_model_i.write(ADDR_OR_MASK, 16'h0000);
    // short time constants: rx 1, switch 2, amp 3, switch off 1, amp off 2
    host_model_i.write(ADDR_TIME_CONST, 16'h28CA);
    host_model_i.read(ADDR_TIME_CONST, d);
    check(d, 16'h28CA, "tc rw");
    pulse(0);
    watch(400);
    check(16'(t_edge[TX]), 16'h012D, "tx on");
    check(16'(t_edge[MOD]), 16'h012D, "mod on");
    check(16'(t_edge[SW]), 16'h0065, "switch lead");
    check(16'(t_edge[AMP]), 16'h0001, "amp lead");
    check({11'h000, pa}, 16'h0018, "tx ctrl");
    // tail times count from the edge that takes the last-chip pulse
    pulse(1);
    check({15'h0000, o_tx_enable}, 16'h0000, "tx off");
    watch(300);
    check(16'(t_edge[SW]), 16'h0065, "switch off");
    check(16'(t_edge[AMP]), 16'h00C9, "amp off");
    check(16'(t_edge[MOD]), 16'h00C9, "mod off");
    check({11'h000, pa}, 16'h0007, "idle ctrl");
    pulse(2);
    watch(600);
    check(16'(t_edge[DEM]), 16'h01F5, "demod on");
    pulse(3);
    watch(4);
    check({11'h000, seq}, 16'h0000, "rx stop");
    // a last-chip pulse in idle is ignored
    pulse(1);
    watch(10);
    check({11'h000, seq}, 16'h0000, "stray last chip");
    // tx start taken while waiting in rx
    pulse(2);
    pulse(0);
    watch(400);
    check(16'(t_edge[TX]), 16'h012D, "tx from rx");
    check({15'h0000, o_demod_enable}, 16'h0000, "demod in tx");
    pulse(1);
    watch(300);
    check({11'h000, seq}, 16'h0000, "tail from rx");
    complete_run;
  end

  // watchdog against a hang
  initial
  begin
    #100000;
    mismatches++;
    $display("BAD %0t watchdog expired", $time);
    complete_run;
  end
endmodule // testbench
